// ==== sfwp_top.sv ====
// Write enable latch, block protection, pulse-count check and hold control
// Behaviour
// - Write-enable command sets latch; modifying commands rejected while latch clear.
// - Latch clears at reset and on completing program, erase, register write, disable.
// - Program and erase inside the block-protected region are ignored; reads stay allowed.
// - Write-protect pin level combined with write-disable bit gives hardware protection.
// - Program, erase, register write execute only on clock counts multiple of eight.
// - Origin 0: codes 1..6 protect from FC0000h..800000h up to FFFFFFh.
// - Origin 1: codes 1..6 protect 000000h up to 03FFFFh..7FFFFFh.
// - Code 000 protects nothing, 111 everything, others 1/64 doubling to 1/2.
// - Hold suspends the serial link only; running operations finish.
// - Hold starts on hold falling with clock low, else at next falling clock.
// - Hold ends on hold rising with clock low, else at next falling clock.
// - During hold the data output floats; data input and clock are ignored.
// - Host keeps select low in hold; select rising resets the serial interface.
// - Hold function is disabled in quad mode.
// - High voltage on the accelerate pin shortens program operations.
// - Accelerated programming is disabled in quad mode.
// - Write-disable set with protect pin low makes status protection bits read-only.
// - Volatile protection option loads block-protect bits with 111 at power-on.
// - Freeze bit locks block-protect and origin bits until power-on reset.
// - Quad mode turns protect pin and hold pin into data lines.
`timescale 1ns/1ps

module sfwp_link
	import sfwp_pkg::*;
(
	input wire logic sck_i,
	input wire logic clr_i,
	input wire logic si_i,
	input wire logic hold_n_i,
	input wire logic quad_i,
	output logic [31:0] shift_o,
	output logic [11:0] cnt_o,
	output logic full_o
);
	typedef struct packed {
		logic [31:0] sh;
		logic [11:0] cnt;
		logic full;
	} sfwp_link_t;

	sfwp_link_t q;
	sfwp_link_t d;

	// Hold pin is sampled on the clock itself: a low level at a rising edge
	// means the pin fell while the clock was low, so the edge is not ours
	always_comb begin
		d = q;
		if (quad_i || hold_n_i) begin
			d.cnt = q.cnt + 12'h001;
			if (!q.full) begin
				d.sh = {q.sh[30:0], si_i};
				d.full = (q.cnt == 12'(LINK_W - 1));
			end
		end
	end

	// Cleared by the core between frames; the clock is idle then
	always_ff @(posedge sck_i or posedge clr_i) begin
		if (clr_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign shift_o = q.sh;
	assign cnt_o = q.cnt;
	assign full_o = q.full;
endmodule : sfwp_link

module sfwp_top
	import sfwp_pkg::*;
#(
	parameter int PROG_CYCLES = 60000,
	parameter int ACCEL_CYCLES = 20000,
	parameter int ERASE_CYCLES = 400000,
	parameter int BULK_CYCLES = 800000,
	parameter int REG_CYCLES = 8000
)
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic SCK_I,
	input wire logic CS_N_I,
	input wire logic SI_I,
	input wire logic HOLD_N_I,
	input wire logic WP_N_I,
	input wire logic ACC_HV_I,
	input wire logic [7:0] NV_STATUS_I,
	input wire logic [7:0] NV_CONFIG_I,
	input wire logic SO_EN_I,
	output logic SO_OE_O,
	output logic HOLD_O,
	output logic WEL_O,
	output logic [2:0] BP_O,
	output logic STATUS_WRITE_DISABLE_O,
	output logic ORIGIN_O,
	output logic VOLATILE_O,
	output logic FREEZE_O,
	output logic QUAD_O,
	output logic HW_PROT_O,
	output logic ACCEL_O,
	output logic BUSY_O,
	output logic OP_START_O,
	output logic [7:0] OP_CMD_O,
	output logic [23:0] OP_ADDR_O,
	output logic REJECT_O
);
	initial begin
		if (PROG_CYCLES < 1 || ACCEL_CYCLES < 1 || ERASE_CYCLES < 1 || BULK_CYCLES < 1
				|| REG_CYCLES < 1 || PROG_CYCLES >= (1 << TIMER_W)
				|| ACCEL_CYCLES >= (1 << TIMER_W) || ERASE_CYCLES >= (1 << TIMER_W)
				|| BULK_CYCLES >= (1 << TIMER_W) || REG_CYCLES >= (1 << TIMER_W)) begin
			$error("sfwp_top: operation cycle counts out of range");
		end
	end

	typedef struct packed {
		logic cs_m;
		logic cs_s;
		logic cs_d;
		logic hold_m;
		logic hold_s;
		logic sck_m;
		logic sck_s;
		logic wp_m;
		logic wp_s;
		logic acc_m;
		logic acc_s;
		sfwp_state_t state;
		logic [1:0] clr_cnt;
		logic clr;
		logic init;
		logic write_enable_latch;
		logic [2:0] bp;
		logic status_write_disable;
		logic origin;
		logic vol;
		logic freeze;
		logic quad;
		logic hw_prot;
		logic accel;
		logic hold;
		logic so_oe;
		logic [19:0] timer;
		logic busy;
		logic op_start;
		logic [7:0] op_cmd;
		logic [23:0] op_addr;
		logic reject;
	} sfwp_core_t;

	localparam sfwp_core_t CORE_RESET = '{
		cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1, hold_m: 1'b1, hold_s: 1'b1,
		sck_m: 1'b0, sck_s: 1'b0, wp_m: 1'b1, wp_s: 1'b1, acc_m: 1'b0, acc_s: 1'b0,
		state: ST_IDLE, clr_cnt: 2'h0, clr: 1'b1, init: 1'b1, write_enable_latch: 1'b0, bp: BP_NONE,
		status_write_disable: 1'b0, origin: 1'b0, vol: 1'b0, freeze: 1'b0, quad: 1'b0,
		hw_prot: 1'b0, accel: 1'b0, hold: 1'b0, so_oe: 1'b0, timer: TIMER_ZERO,
		busy: 1'b0, op_start: 1'b0, op_cmd: 8'h00, op_addr: 24'h000000, reject: 1'b0
	};

	localparam logic [19:0] PROG_T = 20'(PROG_CYCLES);
	localparam logic [19:0] ACCEL_T = 20'(ACCEL_CYCLES);
	localparam logic [19:0] ERASE_T = 20'(ERASE_CYCLES);
	localparam logic [19:0] BULK_T = 20'(BULK_CYCLES);
	localparam logic [19:0] REG_T = 20'(REG_CYCLES);

	function automatic logic is_program(input logic [7:0] c);
		return c == CMD_PAGE_PROGRAM || c == CMD_QUAD_PAGE_PROGRAM
			|| c == CMD_OTP_BYTE_PROGRAM;
	endfunction : is_program

	function automatic logic is_addr_erase(input logic [7:0] c);
		return c == CMD_SECTOR_ERASE || c == CMD_SMALL_SUBSECTOR_ERASE
			|| c == CMD_LARGE_SUBSECTOR_ERASE;
	endfunction : is_addr_erase

	function automatic logic is_modify(input logic [7:0] c);
		return is_program(c) || is_addr_erase(c) || c == CMD_BULK_ERASE
			|| c == CMD_REGISTER_WRITE;
	endfunction : is_modify

	// Codes 1..6 cover 2^(n-1) granules at the chosen end of the array
	function automatic logic prot_hit(input logic [23:0] a, input logic [2:0] bp,
			input logic bottom);
		logic [5:0] mask;
		logic [5:0] idx;
		mask = 6'h3F << (bp - 3'h1);
		idx = a[23:GRAN_LOG2];
		if (bp == BP_NONE) begin
			return 1'b0;
		end else if (bp == BP_ALL) begin
			return 1'b1;
		end else if (bottom) begin
			return (idx & mask) == 6'h00;
		end else begin
			return (idx & mask) == mask;
		end
	endfunction : prot_hit

	// Frames shorter than the capture window are left-justified
	function automatic logic [31:0] align(input logic [31:0] sh, input logic [11:0] cnt,
			input logic full);
		logic [5:0] gap;
		gap = 6'(LINK_W) - cnt[5:0];
		return full ? sh : (sh << gap);
	endfunction : align

	sfwp_core_t q;
	sfwp_core_t d;
	logic [31:0] link_sh;
	logic [11:0] link_cnt;
	logic link_full;

	// Quad setting only changes between frames, so the link reads it as static
	sfwp_link u_link (
		.sck_i(SCK_I),
		.clr_i(q.clr),
		.si_i(SI_I),
		.hold_n_i(HOLD_N_I),
		.quad_i(q.quad),
		.shift_o(link_sh),
		.cnt_o(link_cnt),
		.full_o(link_full)
	);

	always_comb begin
		logic [31:0] word;
		logic [7:0] cmd;
		logic [23:0] addr;
		logic mult8;
		logic len_ok;
		logic blocked;
		word = align(link_sh, link_cnt, link_full);
		cmd = word[31:24];
		addr = word[23:0];
		mult8 = (link_cnt[2:0] == 3'h0) && (link_cnt != 12'h000);
		len_ok = 1'b0;
		blocked = 1'b0;
		d = q;
		d.cs_m = CS_N_I;
		d.cs_s = q.cs_m;
		d.cs_d = q.cs_s;
		d.hold_m = HOLD_N_I;
		d.hold_s = q.hold_m;
		d.sck_m = SCK_I;
		d.sck_s = q.sck_m;
		d.wp_m = WP_N_I;
		d.wp_s = q.wp_m;
		d.acc_m = ACC_HV_I;
		d.acc_s = q.acc_m;
		d.op_start = 1'b0;
		d.reject = 1'b0;

		// Clock low follows the pin at once; clock high defers to the next fall
		if (q.quad || q.cs_s) begin
			d.hold = 1'b0;
		end else if (!q.sck_s) begin
			d.hold = !q.hold_s;
		end

		if (q.init) begin
			d.init = 1'b0;
			d.status_write_disable = NV_STATUS_I[SR_WRITE_DISABLE_POS];
			d.origin = NV_CONFIG_I[CR_ORIGIN_POS];
			d.vol = NV_CONFIG_I[CR_VOLATILE_POS];
			d.quad = NV_CONFIG_I[CR_QUAD_POS];
			d.freeze = 1'b0;
			d.bp = NV_CONFIG_I[CR_VOLATILE_POS] ? BP_ALL
				: NV_STATUS_I[SR_BP_LSB +: 3];
		end

		// Running operations ignore hold and only end on their own count
		if (q.timer != TIMER_ZERO) begin
			d.timer = q.timer - TIMER_ONE;
			if (q.timer == TIMER_ONE) begin
				d.write_enable_latch = 1'b0;
			end
		end

		case (q.state)
			ST_IDLE: begin
				if (q.cs_s && !q.cs_d) begin
					d.state = ST_DECODE;
				end
			end
			ST_DECODE: begin
				d.state = ST_CLEAR;
				d.clr_cnt = CLR_CYCLES;
				if (q.timer == TIMER_ZERO && link_cnt != 12'h000) begin
					if (cmd == CMD_WRITE_ENABLE && link_cnt == CNT_CMD_ONLY) begin
						d.write_enable_latch = 1'b1;
					end else if (cmd == CMD_WRITE_DISABLE && link_cnt == CNT_CMD_ONLY) begin
						d.write_enable_latch = 1'b0;
					end else if (is_modify(cmd)) begin
						if (cmd == CMD_REGISTER_WRITE) begin
							len_ok = link_cnt == CNT_SR_ONLY || link_cnt == CNT_SR_CR;
						end else if (cmd == CMD_BULK_ERASE) begin
							len_ok = link_cnt == CNT_CMD_ONLY;
							blocked = q.bp != BP_NONE;
						end else begin
							len_ok = link_full;
							blocked = prot_hit(addr, q.bp, q.origin);
						end
						if (q.write_enable_latch && mult8 && len_ok && !blocked) begin
							d.op_start = 1'b1;
							d.op_cmd = cmd;
							d.op_addr = (cmd == CMD_REGISTER_WRITE) ? 24'h000000 : addr;
							if (is_program(cmd)) begin
								d.timer = q.accel ? ACCEL_T : PROG_T;
							end else if (cmd == CMD_BULK_ERASE) begin
								d.timer = BULK_T;
							end else if (is_addr_erase(cmd)) begin
								d.timer = ERASE_T;
							end else begin
								d.timer = REG_T;
								if (!q.hw_prot) begin
									d.status_write_disable = word[16 + SR_WRITE_DISABLE_POS];
								end
								if (!q.hw_prot && !q.freeze) begin
									d.bp = word[16 + SR_BP_LSB +: 3];
								end
								if (link_cnt == CNT_SR_CR && !q.freeze) begin
									d.origin = q.origin | word[8 + CR_ORIGIN_POS];
									d.vol = q.vol | word[8 + CR_VOLATILE_POS];
									d.quad = word[8 + CR_QUAD_POS];
									d.freeze = word[8 + CR_FREEZE_POS];
								end
							end
						end else begin
							d.reject = 1'b1;
						end
					end
				end
			end
			ST_CLEAR: begin
				d.clr_cnt = q.clr_cnt - 2'h1;
				if (q.clr_cnt == 2'h1) begin
					d.state = ST_IDLE;
				end
			end
			default: begin
				d.state = ST_IDLE;
			end
		endcase

		// Clear starts the cycle after decode, so decode still reads the frame
		d.clr = q.state != ST_IDLE;
		d.busy = d.timer != TIMER_ZERO;
		d.hw_prot = d.status_write_disable && !q.wp_s && !d.quad;
		d.accel = q.acc_s && !d.quad;
		d.so_oe = SO_EN_I && !q.cs_s && !d.hold;
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			q <= CORE_RESET;
		end else begin
			q <= d;
		end
	end

	assign SO_OE_O = q.so_oe;
	assign HOLD_O = q.hold;
	assign WEL_O = q.write_enable_latch;
	assign BP_O = q.bp;
	assign STATUS_WRITE_DISABLE_O = q.status_write_disable;
	assign ORIGIN_O = q.origin;
	assign VOLATILE_O = q.vol;
	assign FREEZE_O = q.freeze;
	assign QUAD_O = q.quad;
	assign HW_PROT_O = q.hw_prot;
	assign ACCEL_O = q.accel;
	assign BUSY_O = q.busy;
	assign OP_START_O = q.op_start;
	assign OP_CMD_O = q.op_cmd;
	assign OP_ADDR_O = q.op_addr;
	assign REJECT_O = q.reject;
endmodule : sfwp_top

// ==== sfwp_pkg.sv ====
// Constants and types for the serial flash write-protect and hold block
package sfwp_pkg;
	localparam int ADDR_W = 24;
	localparam int CMD_W = 8;
	localparam int LINK_W = 32;
	localparam int CNT_W = 12;
	localparam int BYTE_BITS = 8;
	localparam int TIMER_W = 20;
	// Protection granule is 256 KB, so the top six address bits index it
	localparam int GRAN_LOG2 = 18;
	localparam int GRAN_IDX_W = 6;
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_REGISTER_WRITE = 8'h01;
	localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM = 8'h32;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD8;
	localparam logic [7:0] CMD_BULK_ERASE = 8'hC7;
	localparam logic [7:0] CMD_SMALL_SUBSECTOR_ERASE = 8'h20;
	localparam logic [7:0] CMD_LARGE_SUBSECTOR_ERASE = 8'h40;
	localparam logic [7:0] CMD_OTP_BYTE_PROGRAM = 8'h42;
	localparam int SR_WRITE_DISABLE_POS = 7;
	localparam int SR_BP_LSB = 2;
	localparam int CR_ORIGIN_POS = 5;
	localparam int CR_VOLATILE_POS = 3;
	localparam int CR_QUAD_POS = 1;
	localparam int CR_FREEZE_POS = 0;
	localparam logic [2:0] BP_NONE = 3'h0;
	localparam logic [2:0] BP_ALL = 3'h7;
	localparam logic [11:0] CNT_CMD_ONLY = 12'h008;
	localparam logic [11:0] CNT_SR_ONLY = 12'h010;
	localparam logic [11:0] CNT_SR_CR = 12'h018;
	localparam logic [1:0] CLR_CYCLES = 2'h2;
	localparam logic [19:0] TIMER_ZERO = 20'h00000;
	localparam logic [19:0] TIMER_ONE = 20'h00001;
	typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_CLEAR} sfwp_state_t;
endpackage : sfwp_pkg

// ==== sfwp_checker.sv ====
// Assertions on the write-protect and hold block outputs
`timescale 1ns/1ps
module sfwp_checker (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CS_N_I,
	input wire logic SO_OE_O,
	input wire logic HOLD_O,
	input wire logic WEL_O,
	input wire logic [2:0] BP_O,
	input wire logic STATUS_WRITE_DISABLE_O,
	input wire logic ORIGIN_O,
	input wire logic FREEZE_O,
	input wire logic QUAD_O,
	input wire logic HW_PROT_O,
	input wire logic ACCEL_O,
	input wire logic BUSY_O,
	input wire logic OP_START_O,
	input wire logic REJECT_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// Select deasserted long enough to pass the synchroniser
	sequence cs_idle_s;
		$rose(CS_N_I) ##0 CS_N_I [*6];
	endsequence
	sequence no_start_s;
		!OP_START_O && !$rose(BUSY_O) ##1 !OP_START_O;
	endsequence
	start_wel_a: assert property (OP_START_O |-> $past(WEL_O)) else $error("start without latch");
	start_busy_a: assert property (OP_START_O |-> ##[0:1] BUSY_O) else $error("start not busy");
	reject_quiet_a: assert property (REJECT_O |-> no_start_s) else $error("reject started op");
	wel_done_a: assert property ($fell(BUSY_O) |-> !WEL_O) else $error("latch kept");
	hold_float_a: assert property (HOLD_O && $past(HOLD_O) |-> !SO_OE_O) else $error("so driven");
	cs_hold_a: assert property (cs_idle_s |-> !HOLD_O) else $error("hold kept");
	quad_pins_a: assert property (QUAD_O && $past(QUAD_O, 3) |-> !HOLD_O && !ACCEL_O)
		else $error("quad pin use");
	hw_prot_a: assert property (HW_PROT_O |-> STATUS_WRITE_DISABLE_O && !QUAD_O) else $error("hw prot no status_write_disable");
	hw_lock_a: assert property (HW_PROT_O && $past(HW_PROT_O) |-> $stable(STATUS_WRITE_DISABLE_O) && $stable(BP_O))
		else $error("hw lock broken");
	freeze_lock_a: assert property (FREEZE_O && $past(FREEZE_O) |-> $stable(BP_O) && $stable(ORIGIN_O))
		else $error("freeze broken");
endmodule : sfwp_checker

bind sfwp_top sfwp_checker i_sfwp_checker (.CLK_I(CLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I),
	.SO_OE_O(SO_OE_O), .HOLD_O(HOLD_O), .WEL_O(WEL_O), .BP_O(BP_O), .STATUS_WRITE_DISABLE_O(STATUS_WRITE_DISABLE_O),
	.ORIGIN_O(ORIGIN_O), .FREEZE_O(FREEZE_O), .QUAD_O(QUAD_O), .HW_PROT_O(HW_PROT_O),
	.ACCEL_O(ACCEL_O), .BUSY_O(BUSY_O), .OP_START_O(OP_START_O), .REJECT_O(REJECT_O));

// ==== sfwp_host.sv ====
// Host serial controller model driving the flash pins
`timescale 1ns/1ps
module sfwp_host (
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	output logic hold_n_o
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b1;
		hold_n_o = 1'b1;
	end
	// Hold raised before select falls, MSB first
	task automatic frame(input logic [39:0] d, input int n);
		hold_n_o = 1'b1;
		#10 cs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			si_o = d[39 - (i % 40)];
			#32 sck_o = 1'b1;
			#32 sck_o = 1'b0;
		end
		#20 cs_n_o = 1'b1;
		// Released line must not show a stale bit
		si_o = ~si_o;
	endtask : frame
	task automatic pins(input logic cs, input logic hd, input logic ck);
		#20;
		cs_n_o = cs;
		hold_n_o = hd;
		sck_o = ck;
	endtask : pins
endmodule : sfwp_host

// ==== sfwp_top_bench.sv ====
// Self-checking bench for the write-protect and hold block
`timescale 1ns/1ps
module sfwp_top_bench;
	import sfwp_pkg::*;
	localparam int PC = 20;
	localparam int AC = 5;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wp_n = 1'b1;
	logic acc = 1'b0;
	logic so_en = 1'b1;
	logic [7:0] nvc = 8'h00;
	logic [7:0] nvs = 8'h00;
	logic sck, cs_n, si, hold_n, so_oe, hold, write_enable_latch, status_write_disable, org, vol, frz, quad, hwp, accel, busy;
	logic start, rej;
	logic [2:0] bp;
	logic [7:0] cmd;
	logic [23:0] addr;
	int error_cnt = 0;
	int tests_run = 0;
	int n_st = 0;
	int n_rj = 0;
	int blen = 0;
	always #12.5 clk = ~clk;
	// Pulses are counted away from the edge that launches them
	always @(negedge clk) begin
		n_st += (start === 1'b1);
		n_rj += (rej === 1'b1);
		blen += (busy === 1'b1);
	end
	sfwp_host i_sfwp_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n));
	sfwp_top #(.PROG_CYCLES(PC), .ACCEL_CYCLES(AC), .ERASE_CYCLES(30), .BULK_CYCLES(40),
		.REG_CYCLES(10)) i_sfwp_top (.CLK_I(clk), .RST_I(rst), .SCK_I(sck), .CS_N_I(cs_n),
		.SI_I(si), .HOLD_N_I(hold_n), .WP_N_I(wp_n), .ACC_HV_I(acc), .NV_STATUS_I(nvs),
		.NV_CONFIG_I(nvc), .SO_EN_I(so_en), .SO_OE_O(so_oe), .HOLD_O(hold), .WEL_O(write_enable_latch),
		.BP_O(bp), .STATUS_WRITE_DISABLE_O(status_write_disable), .ORIGIN_O(org), .VOLATILE_O(vol), .FREEZE_O(frz),
		.QUAD_O(quad), .HW_PROT_O(hwp), .ACCEL_O(accel), .BUSY_O(busy), .OP_START_O(start),
		.OP_CMD_O(cmd), .OP_ADDR_O(addr), .REJECT_O(rej));
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	// Gap covers the answer and link clear; busy wait is bounded
	task automatic send(input logic [39:0] d, input int n);
		i_sfwp_host.frame(d, n);
		tick(12);
		for (int k = 0; k < 200 && busy !== 1'b0; k++) tick(1);
		if (busy !== 1'b0) begin
			error_cnt++;
			$display("Error at %0t: operation never finished", $time);
		end
	endtask : send
	task automatic wr(input logic [39:0] d, input int n);
		send({8'h06, 32'h0}, 8);
		blen = 0;
		send(d, n);
	endtask : wr
	task automatic op(input logic [39:0] d, input int n, input logic ok);
		int s;
		int r;
		s = n_st;
		r = n_rj;
		wr(d, n);
		chk(24'(n_st - s), {23'h0, ok});
		chk(24'(n_rj - r), {23'h0, !ok});
	endtask : op
	function automatic logic [39:0] pp(input logic [23:0] a);
		return {8'h02, a, 8'h00};
	endfunction : pp
	task automatic t_basic();
		logic [7:0] ops [6] = '{8'h02, 8'h32, 8'hD8, 8'h20, 8'h40, 8'h42};
		int r;
		send({8'h06, 32'h0}, 8);
		chk(write_enable_latch, 1'b1);
		send({8'h04, 32'h0}, 8);
		chk(write_enable_latch, 1'b0);
		r = n_rj;
		send(pp(24'h0), 32);
		chk(24'(n_rj - r), 24'h1);
		op(pp(24'h000100), 32, 1'b1);
		chk(24'(blen), 24'(PC));
		foreach (ops[i]) begin
			op({ops[i], 24'h123456, 8'h00}, 32, 1'b1);
			chk(cmd, ops[i]);
			chk(addr, 24'h123456);
			chk(write_enable_latch, 1'b0);
		end
		op({8'hC7, 32'h0}, 8, 1'b1);
		chk(write_enable_latch, 1'b0);
		op(pp(24'h0), 33, 1'b0);
		chk(write_enable_latch, 1'b1);
		acc = 1'b1;
		tick(6);
		chk(accel, 1'b1);
		op(pp(24'h0), 32, 1'b1);
		chk(24'(blen), 24'(AC));
		acc = 1'b0;
		tick(6);
		chk(accel, 1'b0);
		op(pp(24'h000200), 32, 1'b1);
		chk(24'(blen), 24'(PC));
		$display("Test basic done");
	endtask : t_basic
	task automatic t_prot(input logic o);
		int sz;
		logic [23:0] p;
		for (int c = 0; c < 8; c++) begin
			op({8'h01, 3'h0, 3'(c), 2'h0, 2'h0, o, 5'h0, 16'h0}, 24, 1'b1);
			chk(bp, 24'(c));
			chk(org, o);
			if (c % 7 == 0) begin
				op(pp(24'h0), 32, c == 0);
				op(pp(24'hFFFFFF), 32, c == 0);
			end else begin
				sz = 'h40000 << (c - 1);
				p = o ? 24'(sz - 1) : 24'('h1000000 - sz);
				op(pp(p), 32, 1'b0);
				op(pp(o ? p + 24'h1 : p - 24'h1), 32, 1'b1);
			end
		end
		$display("Test protection done");
	endtask : t_prot
	task automatic t_wp();
		op({8'h01, 8'h8C, 8'h20, 16'h0}, 24, 1'b1);
		chk(status_write_disable, 1'b1);
		wp_n = 1'b0;
		tick(6);
		chk(hwp, 1'b1);
		wr({8'h01, 8'h00, 24'h0}, 16);
		chk(bp, 3'h3);
		chk(status_write_disable, 1'b1);
		wp_n = 1'b1;
		tick(6);
		chk(hwp, 1'b0);
		$display("Test write protect done");
	endtask : t_wp
	task automatic hp(input logic cs, input logic hd, input logic ck, input logic e);
		i_sfwp_host.pins(cs, hd, ck);
		tick(6);
		chk(hold, e);
	endtask : hp
	task automatic t_hold();
		hp(1'b0, 1'b1, 1'b0, 1'b0);
		chk(so_oe, 1'b1);
		so_en = 1'b0;
		tick(2);
		chk(so_oe, 1'b0);
		so_en = 1'b1;
		hp(1'b0, 1'b0, 1'b0, 1'b1);
		chk(so_oe, 1'b0);
		i_sfwp_host.pins(1'b0, 1'b0, 1'b1);
		hp(1'b0, 1'b1, 1'b1, 1'b1);
		hp(1'b0, 1'b1, 1'b0, 1'b0);
		i_sfwp_host.pins(1'b0, 1'b1, 1'b1);
		hp(1'b0, 1'b0, 1'b1, 1'b0);
		hp(1'b0, 1'b0, 1'b0, 1'b1);
		hp(1'b1, 1'b0, 1'b0, 1'b0);
		hp(1'b1, 1'b1, 1'b0, 1'b0);
		$display("Test hold done");
	endtask : t_hold
	task automatic t_quad();
		acc = 1'b1;
		op({8'h01, 8'h00, 8'h22, 16'h0}, 24, 1'b1);
		chk(quad, 1'b1);
		chk(accel, 1'b0);
		hp(1'b0, 1'b1, 1'b0, 1'b0);
		hp(1'b0, 1'b0, 1'b0, 1'b0);
		hp(1'b1, 1'b1, 1'b0, 1'b0);
		wr({8'h01, 8'h00, 8'h23, 16'h0}, 24);
		chk(frz, 1'b1);
		wr({8'h01, 8'h14, 8'h03, 16'h0}, 24);
		chk(bp, 3'h0);
		chk(org, 1'b1);
		acc = 1'b0;
		$display("Test quad and freeze done");
	endtask : t_quad
	initial begin
		tick(5);
		rst = 1'b0;
		tick(6);
		t_basic();
		t_prot(1'b0);
		t_prot(1'b1);
		t_wp();
		t_hold();
		t_quad();
		send({8'h06, 32'h0}, 8);
		chk(write_enable_latch, 1'b1);
		nvc = 8'h08;
		nvs = 8'h84;
		rst = 1'b1;
		tick(5);
		rst = 1'b0;
		tick(6);
		chk(bp, 3'h7);
		chk(frz, 1'b0);
		chk(write_enable_latch, 1'b0);
		chk(status_write_disable, 1'b1);
		chk(vol, 1'b1);
		chk(quad, 1'b0);
		$display("Test power-on done");
		end_sim();
	end
	// Expected run is near 0.2 ms
	initial begin
		#2000000;
		error_cnt++;
		$display("Error at %0t: watchdog expired", $time);
		end_sim();
	end
endmodule : sfwp_top_bench
